// ===== hw/fpi_regs.svh
// Purpose: Register offsets, field positions, reset values and timing
// Assumes: 32-bit AHB-Lite register bus, 50 MHz system clock
`ifndef FPI_REGS_SVH
`define FPI_REGS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define FPI_REG_SEL_BIT   13
`define FPI_CTRL_OFS      14'h2000
`define FPI_PROTECT_OFS   14'h2004
`define FPI_STATUS_OFS    14'h2008

// ****************************************************************
// Reset values
// ****************************************************************
`define FPI_CTRL_RST      32'h0000_0000
`define FPI_PROTECT_RST   8'hFF

// ****************************************************************
// Status field positions
// ****************************************************************
`define FPI_STAT_PERMIT_BIT  8
`define FPI_STAT_MAP_BIT     9

// ****************************************************************
// Timing
// ****************************************************************
`define FPI_CLK_NS        20
`define FPI_PULSE_UNIT_NS 1000

`endif

// ===== hw/fpi_pkg.sv
// Purpose: Types shared by the program interlock
// Assumes: Field layout of the control word as below
// Notes:   Struct runs MSB first
package fpi_pkg;

  // Interlock states, one-hot
  typedef enum logic [4:0] {
    FPI_NORMAL   = 5'b00001,
    FPI_FIRST    = 5'b00010,
    FPI_EXPANDED = 5'b00100,
    FPI_PROGRAM  = 5'b01000,
    FPI_MARGIN   = 5'b10000
  } fpi_state_e;

  // Control word layout
  typedef struct packed {
    logic [7:0] block_select;
    logic [3:0] rsvd_hi;
    logic [3:0] pulse_multiplier;
    logic       rsvd_mid;
    logic [2:0] pulse_exponent;
    logic [2:0] pulse_clock_prescale;
    logic       level_select_b;
    logic       level_select_a;
    logic [2:0] algorithm_select;
    logic       high_voltage_status;
    logic       high_voltage_enable;
    logic       erase_select;
    logic       sequence_enable;
  } fpi_ctrl_s;

  // Captured AHB address phase
  typedef struct packed {
    logic [31:0] addr;
    logic        write;
  } fpi_dphase_s;

endpackage

// ===== hw/fpi_top.sv
// Purpose: Flash program interlock with page buffers and AHB slave
// Assumes: Single AHB-Lite master, word transfers only
// Notes:   Cell array modelled as a programmed-bit mask
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "fpi_regs.svh"

module fpi_top #(
  parameter int BLOCKS         = 8,
  parameter int WORDS          = 16,
  parameter int PAGE_BITS      = 2,
  parameter int PULSE_UNIT_CYC = `FPI_PULSE_UNIT_NS / `FPI_CLK_NS
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // System pins
  input  wire logic        ext_program_permit,
  input  wire logic        mem_map_en,
  input  wire logic        soft_rst,
  // Programming supply drive
  output logic             hv_active
);
  import fpi_pkg::*;

  localparam int PAGES = 1 << PAGE_BITS;
  localparam int WB    = $clog2(WORDS);
  localparam int BB    = $clog2(BLOCKS);
  localparam int CELLS = BLOCKS * PAGES * WORDS;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  generate
    if (BLOCKS != 8 || WORDS != 16 || PAGE_BITS < 1 ||
        WB + BB + PAGE_BITS + 2 > `FPI_REG_SEL_BIT ||
        PULSE_UNIT_CYC < 1) begin : g_bad_cfg
      $error("fpi_top: unsupported geometry");
    end
  endgenerate

  // Flat cell index from block, page and word
  function automatic int cell_idx(input int b, input int p, input int w);
    cell_idx = (b * PAGES + p) * WORDS + w;
  endfunction

  // ****************************************************************
  // Reset release and pin synchroniser
  // ****************************************************************
  logic rst_s1_reg, rst_sync_n;
  logic ep_s1_reg, ep_s2_reg, ep_s3_reg, ep_ok_reg, ep_ok_next;

  // Reset asserts at once, releases after two edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_sync_n <= rst_s1_reg;
    end
  end

  // Permit level only changes once stages two and three agree
  always_comb begin
    ep_ok_next = ep_ok_reg;
    if (ep_s2_reg == ep_s3_reg) begin
      ep_ok_next = ep_s3_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ep_s1_reg <= 1'b0;
      ep_s2_reg <= 1'b0;
      ep_s3_reg <= 1'b0;
      ep_ok_reg <= 1'b0;
    end else begin
      ep_s1_reg <= ext_program_permit;
      ep_s2_reg <= ep_s1_reg;
      ep_s3_reg <= ep_s2_reg;
      ep_ok_reg <= ep_ok_next;
    end
  end

  // ****************************************************************
  // Control state
  // ****************************************************************
  fpi_state_e           state_reg, state_next;
  fpi_ctrl_s            ctrl_reg, ctrl_next, wd;
  fpi_dphase_s          dp_reg, dp_next;
  logic [7:0]           protect_reg, protect_next;
  logic [PAGE_BITS-1:0] offset_reg, offset_next, page_eff;
  logic [31:0]          timer_reg, timer_next, rdata_next;
  logic                 dp_valid_reg, dp_valid_next;
  logic                 ready_reg, ready_next, hv_reg, hv_next;
  logic                 arr, act, wr_ctrl, wr_prot, wr_arr, rd_arr;
  logic                 pulse_done, margin_upd, clear_bufs;
  logic [BB-1:0]        blk;
  logic [WB-1:0]        wrd;
  logic [13:0]          ofs;

  // Programmed-bit mask of the cells and the page buffers
  logic [31:0]          cell_zero [CELLS];
  logic [31:0]          buf_pend  [BLOCKS][WORDS];
  logic                 buf_used  [BLOCKS][WORDS];

  // Bus decode, transitions and register next values
  always_comb begin
    wd            = fpi_ctrl_s'(hwdata);
    ofs           = dp_reg.addr[13:0];
    arr           = !dp_reg.addr[`FPI_REG_SEL_BIT];
    blk           = dp_reg.addr[WB+BB+1:WB+2];
    wrd           = dp_reg.addr[WB+1:2];
    // Accesses after the first write stay on the latched page
    page_eff      = dp_reg.addr[WB+BB+PAGE_BITS+1:WB+BB+2];
    if (state_reg inside {FPI_EXPANDED, FPI_MARGIN}) begin
      page_eff    = offset_reg;
    end
    // Array holds the bus while high voltage is on
    act           = dp_valid_reg && !(arr && state_reg == FPI_PROGRAM);
    wr_ctrl       = act && dp_reg.write && !arr && ofs == `FPI_CTRL_OFS;
    wr_prot       = act && dp_reg.write && !arr &&
                    ofs == `FPI_PROTECT_OFS;
    // Buffer writes only before the first pulse
    wr_arr        = act && dp_reg.write && arr &&
                    state_reg inside {FPI_FIRST, FPI_EXPANDED};
    rd_arr        = act && !dp_reg.write && arr;
    state_next    = state_reg;
    ctrl_next     = ctrl_reg;
    protect_next  = protect_reg;
    offset_next   = offset_reg;
    unique case (state_reg)
      FPI_NORMAL: begin
        if (wr_ctrl && wd.sequence_enable && !wd.erase_select) begin
          state_next = FPI_FIRST;
        end
      end
      FPI_FIRST: begin
        if (wr_ctrl && !wd.sequence_enable) begin
          state_next = FPI_NORMAL;
        end else if (wr_arr) begin
          state_next  = FPI_EXPANDED;
          offset_next = page_eff;
        end
      end
      FPI_EXPANDED, FPI_MARGIN: begin
        if (wr_ctrl && !wd.sequence_enable) begin
          state_next = FPI_NORMAL;
        end else if (wr_ctrl && wd.high_voltage_enable) begin
          state_next = FPI_PROGRAM;
        end
      end
      FPI_PROGRAM: begin
        if (soft_rst || !mem_map_en ||
            (wr_ctrl && !wd.high_voltage_enable)) begin
          state_next = FPI_MARGIN;
        end
      end
    endcase
    // Setup fields frozen while the pulse is on
    if (wr_ctrl && state_reg != FPI_PROGRAM) begin
      ctrl_next = wd;
    end
    if (wr_prot && state_reg == FPI_NORMAL) begin
      protect_next = hwdata[7:0];
    end
    ctrl_next.rsvd_hi             = 4'h0;
    ctrl_next.rsvd_mid            = 1'b0;
    // Enable mirrors the pulse state so it cannot stick
    ctrl_next.high_voltage_enable = state_next == FPI_PROGRAM;
    ctrl_next.sequence_enable     = state_next != FPI_NORMAL;
    // Pulse width counts only when the prescaler is nonzero
    timer_next = 32'h0000_0000;
    if (state_reg != FPI_PROGRAM && state_next == FPI_PROGRAM &&
        ctrl_next.pulse_clock_prescale != 3'h0) begin
      timer_next = ((32'(ctrl_next.pulse_multiplier) + 32'h0000_0001)
                    << ctrl_next.pulse_exponent
                    << ctrl_next.pulse_clock_prescale)
                   * 32'(PULSE_UNIT_CYC);
    end else if (state_next == FPI_PROGRAM && timer_reg != 0) begin
      timer_next = timer_reg - 32'h0000_0001;
    end
    ctrl_next.high_voltage_status = timer_next != 0;
    // Voltage drive needs the pulse state and the permit pin
    hv_next    = state_next == FPI_PROGRAM && ep_ok_reg;
    pulse_done = state_reg == FPI_PROGRAM && state_next != FPI_PROGRAM;
    margin_upd = rd_arr && state_reg inside {FPI_EXPANDED, FPI_MARGIN};
    clear_bufs = state_next == FPI_NORMAL;
  end

  // Bus handshake and read data
  always_comb begin
    dp_next       = dp_reg;
    dp_valid_next = dp_valid_reg;
    ready_next    = ready_reg;
    rdata_next    = hrdata;
    if (act) begin
      // One wait state, then the answer; writes keep old read data
      dp_valid_next = 1'b0;
      ready_next    = 1'b1;
      if (!dp_reg.write) begin
        rdata_next  = 32'h0000_0000;
        if (arr) begin
          // Later reads return margin status of the latched page
          rdata_next = ~cell_zero[cell_idx(int'(blk), int'(page_eff),
                                           int'(wrd))];
        end else if (ofs == `FPI_CTRL_OFS) begin
          rdata_next = ctrl_reg;
        end else if (ofs == `FPI_PROTECT_OFS) begin
          rdata_next = {24'h00_0000, protect_reg};
        end else if (ofs == `FPI_STATUS_OFS) begin
          rdata_next[4:0]                  = state_reg;
          rdata_next[`FPI_STAT_PERMIT_BIT] = ep_ok_reg;
          rdata_next[`FPI_STAT_MAP_BIT]    = mem_map_en;
        end
      end
    end else if (ready_reg && hsel && hready && htrans[1]) begin
      dp_valid_next = 1'b1;
      ready_next    = 1'b0;
      dp_next       = '{addr: haddr, write: hwrite};
    end
  end

  // Register bank
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg    <= FPI_NORMAL;
      ctrl_reg     <= fpi_ctrl_s'(`FPI_CTRL_RST);
      protect_reg  <= `FPI_PROTECT_RST;
      offset_reg   <= '0;
      timer_reg    <= 32'h0000_0000;
      dp_reg       <= '0;
      dp_valid_reg <= 1'b0;
      ready_reg    <= 1'b1;
      hrdata       <= 32'h0000_0000;
      hv_reg       <= 1'b0;
    end else begin
      state_reg    <= state_next;
      ctrl_reg     <= ctrl_next;
      protect_reg  <= protect_next;
      offset_reg   <= offset_next;
      timer_reg    <= timer_next;
      dp_reg       <= dp_next;
      dp_valid_reg <= dp_valid_next;
      ready_reg    <= ready_next;
      hrdata       <= rdata_next;
      hv_reg       <= hv_next;
    end
  end

  assign hreadyout = ready_reg;
  assign hv_active = hv_reg;

  // Response is always OKAY, kept in a flop
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // ****************************************************************
  // Page buffers and cell array
  // ****************************************************************
  // Flash content survives reset in silicon; here reset means erased
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int c = 0; c < CELLS; c++) begin
        cell_zero[c] <= 32'h0000_0000;
      end
      for (int b = 0; b < BLOCKS; b++) begin
        for (int w = 0; w < WORDS; w++) begin
          buf_pend[b][w] <= 32'h0000_0000;
          buf_used[b][w] <= 1'b0;
        end
      end
    end else begin
      for (int b = 0; b < BLOCKS; b++) begin
        for (int w = 0; w < WORDS; w++) begin
          // With permit, the pulse hits every selected, unprotected, written word
          if (pulse_done && ep_ok_reg && buf_used[b][w] &&
              ctrl_reg.block_select[b] && !protect_reg[b]) begin
            // Only set zero bits, never clear them
            cell_zero[cell_idx(b, int'(offset_reg), w)] <=
              cell_zero[cell_idx(b, int'(offset_reg), w)] |
              buf_pend[b][w];
          end
        end
      end
      if (clear_bufs) begin
        for (int b = 0; b < BLOCKS; b++) begin
          for (int w = 0; w < WORDS; w++) begin
            buf_pend[b][w] <= 32'h0000_0000;
            buf_used[b][w] <= 1'b0;
          end
        end
      end else if (wr_arr) begin
        // Zero data bits mark cells to program; newest write wins
        buf_pend[blk][wrd] <= ~hwdata;
        buf_used[blk][wrd] <= 1'b1;
      end else if (margin_upd) begin
        // Drop bits the margin read found programmed
        buf_pend[blk][wrd] <= buf_pend[blk][wrd] &
          ~cell_zero[cell_idx(int'(blk), int'(offset_reg),
                              int'(wrd))];
      end
    end
  end

endmodule

// ===== dv/fpi_sva.sv
// Purpose: Bus and high voltage checks on the interlock ports
// Assumes: One wait state per access, pulse end releases array
// Notes:   Bound into every fpi_top instance
`timescale 1ns/100ps
`include "fpi_regs.svh"

module fpi_sva (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // AHB-Lite
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // Pins
  input wire logic        ext_program_permit,
  input wire logic        soft_rst,
  input wire logic        hv_active
);
  logic acc;
  logic ctl_done;
  logic rd_pend;
  logic arr_pend;
  logic wc_pend;

  // ****************************************************************
  // Data phase tracking
  // ****************************************************************
  assign acc      = hsel & hready & htrans[1];
  assign ctl_done = wc_pend & hreadyout;
  // Pending kinds only move while the slave is ready
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend  <= 1'b0;
      arr_pend <= 1'b0;
      wc_pend  <= 1'b0;
    end else if (hreadyout) begin
      rd_pend  <= acc & ~hwrite;
      arr_pend <= acc & ~haddr[`FPI_REG_SEL_BIT];
      wc_pend  <= acc & hwrite & (haddr[13:0] == `FPI_CTRL_OFS);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_reg_acc;
    acc && haddr[`FPI_REG_SEL_BIT];
  endsequence
  sequence s_wait_done;
    !hreadyout ##1 hreadyout;
  endsequence

  AST_RESP_OKAY: assert property (hresp == 1'b0)
    else $error("error response seen");
  AST_REG_TWO: assert property (s_reg_acc |=> s_wait_done)
    else $error("register access not done in two cycles");
  AST_ARR_WAIT: assert property ((acc && !haddr[13]) |=> !hreadyout)
    else $error("array access without wait state");
  AST_NO_HV: assert property (!ext_program_permit [*6] |-> !hv_active)
    else $error("high voltage while permit low");
  AST_RD_STABLE: assert property (!rd_pend |=> $stable(hrdata))
    else $error("read data changed outside a read");
  AST_SOFT_END: assert property ((soft_rst && arr_pend) |-> ##[1:3] hreadyout)
    else $error("stalled array access not released");
  AST_HV_SRC: assert property ($rose(hv_active) |->
    (ctl_done || $past(ctl_done) || $past(ctl_done, 2)))
    else $error("high voltage without control write");
  AST_HV_END: assert property ((ctl_done && !hwdata[2]) |-> ##[0:2] !hv_active)
    else $error("high voltage stayed after enable clear");
endmodule

bind fpi_top fpi_sva u_sva (
  .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .ext_program_permit(ext_program_permit), .soft_rst(soft_rst),
  .hv_active(hv_active)
);

// ===== dv/fpi_cpu_model.sv
// Purpose: Processor core issuing AHB-Lite single word transfers
// Assumes: One slave whose hreadyout is the bus hready
// Notes:   Idle lines toggle so stale values never pass
`timescale 1ns/100ps

module fpi_cpu_model (
  // Clock
  input  wire logic        clk_sys,
  // AHB-Lite master
  input  wire logic        hready,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  // Quiet bus at time zero
  initial begin
    hsel   = 1'b1;
    haddr  = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = 32'h0000_0000;
  end

  // One transfer; waits as long as the slave stalls
  task automatic xfer(input logic wr, input logic [31:0] a, d);
    @(posedge clk_sys);
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'b00;
    haddr  <= ~a;
    hwdata <= wr ? d : ~hwdata;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hwdata <= ~hwdata;
  endtask
endmodule

// ===== dv/tb_top.sv
// Purpose: Self-checking bench of the program interlock
// Assumes: Pulse unit shortened to one cycle
// Notes:   A monitor checks each read against queued notes
`timescale 1ns/100ps
`include "fpi_regs.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_top;
  import fpi_pkg::*;
  localparam logic [31:0] CTL = 32'h0307_13C1;
  localparam logic [31:0] A_CT = 32'h0000_2000;
  localparam logic [31:0] A_PR = 32'h0000_2004;
  localparam logic [31:0] A_ST = 32'h0000_2008;
  localparam logic [31:0] F = 32'hFFFF_FFFF;
  localparam logic [31:0] S = 32'h0000_001F;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        permit = 1'b0;
  logic        soft_rst = 1'b0;
  logic        map_en = 1'b1;
  logic        hsel, hwrite, hreadyout, hresp, hv_active;
  logic        rd_pend = 1'b0;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, d1, d2, d3;
  logic [63:0] note;
  logic [63:0] note_q[$];
  int          err_total = 0;
  int          compares = 0;
  int          cyc = 0;
  int          seed = 93;
  int          t0, n;

  always #10 clk_sys = ~clk_sys;

  fpi_cpu_model cpu (.clk_sys(clk_sys), .hready(hreadyout), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));
  fpi_top #(.PULSE_UNIT_CYC(1)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .ext_program_permit(permit), .mem_map_en(map_en),
    .soft_rst(soft_rst), .hv_active(hv_active));

  task automatic end_of_test();
    if (err_total == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic rd(input logic [31:0] a, m, e);
    note_q.push_back({m, e & m});
    cpu.xfer(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wr(input logic [31:0] a, d);
    cpu.xfer(1'b1, a, d);
  endtask
  function automatic logic [31:0] aa(input int p, b, w);
    return 32'((p << 9) | (b << 6) | (w << 2));
  endfunction

  // ****************************************************************
  // Read monitor and timeout
  // ****************************************************************
  // Completion is the edge where hready is seen high again
  always @(posedge clk_sys) begin
    if (rd_pend && hreadyout === 1'b1) begin
      note = note_q.pop_front();
      `CHK(hrdata & note[63:32], note[31:0])
    end
    if (hreadyout === 1'b1) rd_pend <= hsel & htrans[1] & ~hwrite;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n  <= 1'b1;
    permit <= 1'b1;
    repeat (4) @(posedge clk_sys);
    d1 = $random(seed);
    d2 = $random(seed);
    d3 = $random(seed);
    rd(A_CT, F, 32'h0000_0000);
    rd(A_PR, F, 32'h0000_00FF);
    rd(A_ST, 32'h0000_031F, 32'h0000_0301);
    rd(32'h0000_200C, F, 32'h0000_0000);
    wr(A_PR, 32'h0000_0002);
    wr(A_CT, CTL);
    rd(A_CT, F, CTL);
    wr(A_PR, 32'h0000_0000);
    rd(A_PR, F, 32'h0000_0002);
    rd(A_ST, S, 32'h0000_0002);
    wr(aa(1, 0, 0), d1);
    rd(A_ST, S, 32'h0000_0004);
    wr(aa(1, 0, 0), d2);
    wr(aa(2, 0, 1), d3);
    wr(aa(1, 1, 0), 32'h0000_0000);
    wr(aa(1, 2, 0), 32'h0000_0000);
    wr(A_CT, CTL | 32'h0000_0004);
    t0 = cyc;
    `CHK(hv_active, 1'b1)
    rd(A_ST, S, 32'h0000_0008);
    rd(A_CT, 32'h0000_0008, 32'h0000_0008);
    n = 0;
    do begin
      rd(A_CT, 32'h0000_0007, 32'h0000_0005);
      n++;
    end while (hrdata[3] !== 1'b0 && n < 50);
    `CHK((cyc - t0 >= 31) && (cyc - t0 <= 44), 1'b1)
    wr(A_CT, CTL);
    rd(A_ST, S, 32'h0000_0010);
    wr(aa(1, 0, 2), 32'h0000_0000);
    rd(aa(1, 0, 0), F, d2);
    rd(aa(3, 0, 0), F, d2);
    rd(aa(1, 0, 1), F, d3);
    rd(aa(1, 1, 0), F, F);
    rd(aa(1, 2, 0), F, F);
    rd(aa(1, 0, 2), F, F);
    rd(aa(1, 0, 8), F, F);
    wr(A_CT, 32'h0000_0000);
    rd(A_ST, S, 32'h0000_0001);
    rd(aa(2, 0, 1), F, F);
    // Second pass: two blocks, pulse cut by soft reset; page one
    // is reprogrammed on purpose to show zeros stay zero
    wr(A_PR, 32'h0000_0000);
    rd(A_PR, F, 32'h0000_0000);
    wr(A_CT, 32'h0907_13C1);
    wr(aa(1, 0, 0), ~d2);
    wr(aa(1, 3, 5), d1);
    wr(A_CT, 32'h0907_13C5);
    fork
      rd(aa(1, 0, 3), F, F);
      begin
        repeat (8) @(posedge clk_sys);
        soft_rst <= 1'b1;
        @(posedge clk_sys);
        soft_rst <= 1'b0;
      end
    join
    rd(A_ST, S, 32'h0000_0010);
    rd(aa(1, 0, 0), F, 32'h0000_0000);
    rd(aa(1, 3, 5), F, d1);
    rd(aa(1, 0, 9), F, F);
    rd(aa(1, 3, 12), F, F);
    wr(A_CT, 32'h0000_0000);
    // Third pass: permit low keeps cells erased
    permit <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd(A_ST, 32'h0000_0100, 32'h0000_0000);
    wr(A_CT, 32'h0107_13C1);
    wr(aa(0, 0, 0), 32'h0000_0000);
    wr(A_CT, 32'h0107_13C5);
    `CHK(hv_active, 1'b0)
    wr(A_CT, 32'h0107_13C1);
    rd(aa(0, 0, 0), F, F);
    wr(A_CT, 32'h0000_0000);
    // Fourth pass: memory map switched off ends the pulse
    wr(A_CT, 32'h0107_13C1);
    wr(aa(2, 1, 4), 32'h0000_0000);
    wr(A_CT, 32'h0107_13C5);
    map_en <= 1'b0;
    @(posedge clk_sys);
    map_en <= 1'b1;
    rd(A_ST, S, 32'h0000_0010);
    wr(A_CT, 32'h0000_0000);
    end_of_test();
  end
endmodule
